// File: rtl/dcs_pkg.sv
// package of register map, field layout and reset values for the dma count and status block
package dcs_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CNT_W = 10;
  // byte offsets on the apb bus
  localparam logic [7:0] OFF_COLL = 8'h00;
  localparam logic [7:0] OFF_CHST = 8'h04;
  localparam logic [7:0] OFF_IMASK = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;
  localparam logic [7:0] OFF_CNT0 = 8'h20;
  // field positions
  localparam int unsigned PCOL_LSB = 8;
  localparam int unsigned RCOL_LSB = 0;
  localparam int unsigned LAST_LSB = 8;
  localparam int unsigned PP_LSB = 0;
  localparam int unsigned IRQ_DONE_LSB = 16;
  // reset values and ping-pong mode encodings
  localparam logic [3:0] LAST_NONE = 4'hf;
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] MODE_PP_CONT = 2'h2;
  localparam logic [1:0] MODE_PP_ONE = 2'h3;
endpackage

// File: rtl/dcs_chan_if.sv
// per-channel signals passed between the top and the channel counter
`timescale 1ns/1ps
`default_nettype none
interface dcs_chan_if;
  logic enable;
  logic xfer;
  logic [1:0] mode;
  logic [9:0] count;
  logic done;
  logic pp_sel;
  modport top(output enable, output xfer, output mode, output count, input done, input pp_sel);
  modport chan(input enable, input xfer, input mode, input count, output done, output pp_sel);
endinterface
`default_nettype wire

// File: rtl/dcs_chan.sv
// one channel: transfer counter, block completion and ping-pong select
`timescale 1ns/1ps
`default_nettype none
module dcs_chan (
  input wire logic clk,
  input wire logic reset_n,
  dcs_chan_if.chan ch
);
  logic [9:0] done_cnt_q;
  logic done_q;
  logic pp_q;
  logic last_xfer;
  assign last_xfer = ch.xfer && (done_cnt_q == ch.count);
  assign ch.done = done_q;
  assign ch.pp_sel = pp_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_cnt_q <= 10'h000;
    end else if (!ch.enable || last_xfer) begin
      done_cnt_q <= 10'h000;
    end else if (ch.xfer) begin
      done_cnt_q <= done_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= ch.enable && last_xfer;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pp_q <= 1'b0;
    end else if (ch.enable && last_xfer && ch.mode[1]) begin
      pp_q <= ~pp_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/dcs_top.sv
// dma transfer count and controller status block with apb register access
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dcs_top #(
  parameter int unsigned NCH = dcs_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic [NCH-1:0] xfer_pulse,
  input wire logic [NCH-1:0] periph_wcol,
  input wire logic [NCH-1:0] ram_wcol,
  output logic [NCH-1:0] block_done,
  output logic [NCH-1:0] buf_select,
  output logic [NCH*10-1:0] count_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic cnt_hit;
  logic [2:0] cnt_idx;
  logic mapped;
  assign acc = psel && penable && !pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign cnt_hit = (paddr[7:5] == dcs_pkg::OFF_CNT0[7:5]) && (paddr[1:0] == 2'h0);
  assign cnt_idx = paddr[4:2];
  assign mapped = cnt_hit || paddr == dcs_pkg::OFF_COLL || paddr == dcs_pkg::OFF_CHST
    || paddr == dcs_pkg::OFF_IMASK || paddr == dcs_pkg::OFF_MODE;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [9:0] cnt_q [NCH];
  logic [1:0] mode_q [NCH];
  logic [NCH-1:0] pcol_q;
  logic [NCH-1:0] rcol_q;
  logic [NCH-1:0] done_st_q;
  logic [3*NCH-1:0] mask_q;
  logic [3:0] last_q;
  logic [NCH-1:0] done_w;
  logic [NCH-1:0] pp_w;
  logic [3*NCH-1:0] status;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_q[i] <= dcs_pkg::CNT_RST;
      end
    end else if (wr && cnt_hit) begin
      cnt_q[cnt_idx] <= pwdata[9:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NCH; i++) begin
        mode_q[i] <= dcs_pkg::MODE_RST;
      end
    end else if (wr && paddr == dcs_pkg::OFF_MODE) begin
      for (int i = 0; i < NCH; i++) begin
        mode_q[i] <= pwdata[2*i +: 2];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= '0;
    end else if (wr && paddr == dcs_pkg::OFF_IMASK) begin
      mask_q <= pwdata[3*NCH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // sticky collision and completion flags, set wins over clear
  // ----------------------------------------------------------------
  logic clr_coll;
  assign clr_coll = wr && paddr == dcs_pkg::OFF_COLL;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pcol_q <= '0;
      rcol_q <= '0;
    end else begin
      pcol_q <= (pcol_q & ~({NCH{clr_coll}} & pwdata[dcs_pkg::PCOL_LSB +: NCH])) | periph_wcol;
      rcol_q <= (rcol_q & ~({NCH{clr_coll}} & pwdata[dcs_pkg::RCOL_LSB +: NCH])) | ram_wcol;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_st_q <= '0;
    end else begin
      done_st_q <= (done_st_q & ~({NCH{clr_coll}} & pwdata[dcs_pkg::IRQ_DONE_LSB +: NCH])) | done_w;
    end
  end

  // ----------------------------------------------------------------
  // last active channel
  // ----------------------------------------------------------------
  logic [3:0] last_d;
  always_comb begin
    last_d = last_q;
    for (int i = 0; i < NCH; i++) begin
      if (xfer_pulse[i] && chan_enable[i]) begin
        last_d = 4'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= dcs_pkg::LAST_NONE;
    end else begin
      last_q <= last_d;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    dcs_chan_if cif ();
    assign cif.enable = chan_enable[g];
    assign cif.xfer = xfer_pulse[g];
    assign cif.mode = mode_q[g];
    assign cif.count = cnt_q[g];
    assign done_w[g] = cif.done;
    assign pp_w[g] = cif.pp_sel;
    dcs_chan u_chan (
      .clk(clk),
      .reset_n(reset_n),
      .ch(cif)
    );
  end

  // ----------------------------------------------------------------
  // outputs and read data
  // ----------------------------------------------------------------
  assign status = {done_st_q, pcol_q, rcol_q};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      block_done <= '0;
      buf_select <= '0;
      count_out <= '0;
      irq <= 1'b0;
    end else begin
      block_done <= done_w;
      buf_select <= pp_w;
      for (int i = 0; i < NCH; i++) begin
        count_out[10*i +: 10] <= cnt_q[i];
      end
      irq <= |(status & mask_q);
    end
  end

  logic [31:0] rdat;
  always_comb begin
    rdat = 32'h0000_0000;
    if (cnt_hit) begin
      rdat[9:0] = cnt_q[cnt_idx];
    end else if (paddr == dcs_pkg::OFF_COLL) begin
      rdat[3*NCH-1:0] = status;
    end else if (paddr == dcs_pkg::OFF_CHST) begin
      rdat[dcs_pkg::LAST_LSB +: 4] = last_q;
      rdat[dcs_pkg::PP_LSB +: NCH] = pp_w;
    end else if (paddr == dcs_pkg::OFF_IMASK) begin
      rdat[3*NCH-1:0] = mask_q;
    end else if (paddr == dcs_pkg::OFF_MODE) begin
      for (int i = 0; i < NCH; i++) begin
        rdat[2*i +: 2] = mode_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= rd ? rdat : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_coll_write(int b);
    clr_coll && pwdata[b];
  endsequence

  sequence s_access;
    psel && penable && !pready;
  endsequence

  sequence s_count0_write;
    s_access ##0 (pwrite && cnt_hit && cnt_idx == 3'h0);
  endsequence

  sequence s_chst_read;
    s_access ##0 (!pwrite && paddr == dcs_pkg::OFF_CHST);
  endsequence

  sequence s_unmapped;
    s_access ##0 !mapped;
  endsequence

  AST_PCOL_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
    periph_wcol[0] |=> pcol_q[0]) else $error("peripheral collision not flagged");
  AST_RCOL_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
    ram_wcol[7] |=> rcol_q[7]) else $error("ram collision not flagged");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (rcol_q[0] && !(clr_coll && pwdata[0])) |=> rcol_q[0]) else $error("flag dropped without clear");
  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    (s_coll_write(8) ##0 !periph_wcol[0]) |=> !pcol_q[0]) else $error("flag not cleared");
  AST_PCOL_NO_SET: assert property (@(posedge clk) disable iff (!reset_n)
    (!pcol_q[7] && !periph_wcol[7]) |=> !pcol_q[7]) else $error("peripheral flag set without event");
  AST_RCOL_NO_SET: assert property (@(posedge clk) disable iff (!reset_n)
    (!rcol_q[1] && !ram_wcol[1]) |=> !rcol_q[1]) else $error("ram flag set without event");
  AST_LAST_CODE: assert property (@(posedge clk) disable iff (!reset_n)
    (last_q <= 4'h7) || (last_q == dcs_pkg::LAST_NONE)) else $error("reserved last channel code");
  AST_LAST_TRACK: assert property (@(posedge clk) disable iff (!reset_n)
    (xfer_pulse[1] && chan_enable[1] && !(|(xfer_pulse[NCH-1:2] & chan_enable[NCH-1:2]))) |=> last_q == 4'h1)
    else $error("last channel wrong");
  AST_LAST_NONE: assert property (@(posedge clk) disable iff (!reset_n)
    (last_q == dcs_pkg::LAST_NONE && !(|(xfer_pulse & chan_enable))) |=> last_q == dcs_pkg::LAST_NONE)
    else $error("last channel changed without transfer");
  AST_PP_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n)
    (done_w[0] && mode_q[0][1]) |-> pp_w[0] != $past(pp_w[0])) else $error("buffer not toggled");
  AST_PP_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !mode_q[1][1] |=> $stable(pp_w[1]) || $past(mode_q[1][1])) else $error("buffer moved outside ping-pong");
  AST_CNT_HI_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    (pready && !pwrite && cnt_hit) |-> prdata[31:10] == 22'h0) else $error("count upper bits not zero");
  AST_BLOCK_LEN: assert property (@(posedge clk) disable iff (!reset_n)
    (chan_enable[1] && cnt_q[1] == 10'h000 && xfer_pulse[1]) |=> done_w[1]) else $error("block length wrong");

  // ----------------------------------------------------------------
  // bus and output checks
  // ----------------------------------------------------------------
  AST_APB_READY: assert property (@(posedge clk) disable iff (!reset_n)
    s_access |=> pready) else $error("access not answered");
  AST_APB_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
    pready |=> !pready) else $error("ready held too long");
  AST_APB_ERR: assert property (@(posedge clk) disable iff (!reset_n)
    pslverr |-> pready) else $error("error without ready");
  AST_APB_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n)
    s_unmapped |=> pslverr) else $error("unmapped access not refused");
  AST_APB_IDLE_DATA: assert property (@(posedge clk) disable iff (!reset_n)
    !pready |-> prdata == 32'h0000_0000) else $error("read data outside access");
  AST_CNT_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    s_count0_write |=> cnt_q[0] == $past(pwdata[9:0])) else $error("count write lost");
  AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !(wr && cnt_hit) |=> $stable(cnt_q[0])) else $error("count changed without write");
  AST_CHST_READ: assert property (@(posedge clk) disable iff (!reset_n)
    s_chst_read |=> prdata[dcs_pkg::LAST_LSB +: 4] == $past(last_q)) else $error("last channel read wrong");
  AST_CHST_HI_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    s_chst_read |=> prdata[31:12] == 20'h0) else $error("status upper bits not zero");
  AST_DONE_OUT: assert property (@(posedge clk) disable iff (!reset_n)
    done_w[0] |=> block_done[0]) else $error("block done not reported");
  AST_DONE_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    !chan_enable[0] |=> !done_w[0]) else $error("block done on disabled channel");
  AST_DONE_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
    done_w[1] |=> done_st_q[1]) else $error("block done not recorded");
  AST_BUF_OUT: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> buf_select == $past(pp_w)) else $error("buffer select output wrong");
  AST_COUNT_OUT: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> count_out[9:0] == $past(cnt_q[0])) else $error("count output wrong");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (!reset_n)
    (|(status & mask_q)) |=> irq) else $error("interrupt not raised");
  AST_IRQ_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    !(|(status & mask_q)) |=> !irq) else $error("interrupt not dropped");
  AST_LAST_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !(|(xfer_pulse & chan_enable)) |=> $stable(last_q)) else $error("last channel moved without transfer");
endmodule
`default_nettype wire

// File: testbench/dcs_far_model.sv
// far-side model: channel engine and collision sources feeding the event inputs
`timescale 1ns/1ps
`default_nettype none
module dcs_far_model (
  input wire logic clk,
  output logic [7:0] chan_enable,
  output logic [7:0] xfer_pulse,
  output logic [7:0] periph_wcol,
  output logic [7:0] ram_wcol
);
  initial begin
    chan_enable = 8'h00;
    xfer_pulse = 8'h00;
    periph_wcol = 8'h00;
    ram_wcol = 8'h00;
  end
  // enables the channel, then gives n one-cycle transfer pulses
  task automatic xfer(input int ch, input int n);
    chan_enable[ch] <= 1'b1;
    repeat (n) begin
      @(posedge clk);
      xfer_pulse[ch] <= 1'b1;
      @(posedge clk);
      xfer_pulse[ch] <= 1'b0;
    end
  endtask
  task automatic wcol(input logic [7:0] p, input logic [7:0] r);
    @(posedge clk);
    periph_wcol <= p;
    ram_wcol <= r;
    @(posedge clk);
    periph_wcol <= 8'h00;
    ram_wcol <= 8'h00;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// testbench for the dma count and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [7:0] chan_enable, xfer_pulse, periph_wcol, ram_wcol, block_done, buf_select;
  logic [31:0] rd;
  logic err;
  logic [7:0] expb;
  int miscompares = 0;
  int n_tests = 0;
  int ndone [8];
  always #5 clk = ~clk;
  always @(posedge clk) for (int i = 0; i < 8; i++) if (block_done[i] === 1'b1) ndone[i]++;
  dcs_top DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_enable(chan_enable), .xfer_pulse(xfer_pulse), .periph_wcol(periph_wcol),
    .ram_wcol(ram_wcol), .block_done(block_done), .buf_select(buf_select), .count_out(), .irq(irq));
  dcs_far_model far (.clk(clk), .chan_enable(chan_enable), .xfer_pulse(xfer_pulse),
    .periph_wcol(periph_wcol), .ram_wcol(ram_wcol));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rdc(dcs_pkg::OFF_CHST, 32'h00000f00);
    rdc(dcs_pkg::OFF_COLL, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, dcs_pkg::OFF_CNT0 + 8'h08, 32'hffffffff);
    chk({31'h0, err}, 32'h0);
    rdc(dcs_pkg::OFF_CNT0 + 8'h08, 32'h000003ff);
    $display("test reset_and_count done");
    apb(1'b1, dcs_pkg::OFF_CNT0, 32'h2);
    apb(1'b1, dcs_pkg::OFF_MODE, 32'h2);
    far.xfer(0, 2);
    repeat (4) @(posedge clk);
    chk(ndone[0], 0);
    far.xfer(0, 1);
    repeat (4) @(posedge clk);
    chk(ndone[0], 1);
    chk({24'h0, buf_select}, 32'h01);
    rdc(dcs_pkg::OFF_CHST, 32'h00000001);
    expb = 8'h01;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, dcs_pkg::OFF_MODE, 32'h2 | (m << 2));
      far.xfer(1, 1);
      repeat (4) @(posedge clk);
      if (m >= 2) expb[1] = ~expb[1];
      chk({24'h0, buf_select}, {24'h0, expb});
    end
    chk(ndone[1], 4);
    rdc(dcs_pkg::OFF_CHST, 32'h00000101);
    $display("test block_and_pingpong done");
    rdc(dcs_pkg::OFF_COLL, 32'h00030000);
    apb(1'b1, dcs_pkg::OFF_COLL, 32'h00ffffff);
    rdc(dcs_pkg::OFF_COLL, 32'h0);
    far.wcol(8'h81, 8'h89);
    repeat (2) @(posedge clk);
    apb(1'b1, dcs_pkg::OFF_COLL, 32'h0);
    rdc(dcs_pkg::OFF_COLL, 32'h00008189);
    apb(1'b1, dcs_pkg::OFF_COLL, 32'h00008100);
    rdc(dcs_pkg::OFF_COLL, 32'h00000089);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, dcs_pkg::OFF_IMASK, 32'h00000008);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, dcs_pkg::OFF_COLL, 32'h00000008);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdc(dcs_pkg::OFF_COLL, 32'h00000081);
    apb(1'b1, dcs_pkg::OFF_COLL, 32'h00000081);
    rdc(dcs_pkg::OFF_COLL, 32'h0);
    $display("test collisions_and_irq done");
    give_verdict();
  end
endmodule
`default_nettype wire
